// ---- verilog/rbt_transceiver.sv ----
`timescale 1ns/10ps

module rbt_transceiver
  import rbt_pkg::*;
(
  // Clock, reset and global freeze.
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // A-to-B controls.
  input  wire logic               a_to_b_capture_clock,
  input  wire logic [NUM_SEC-1:0] a_to_b_store_enable_n,
  input  wire logic               a_to_b_output_enable_n,
  // B-to-A controls.
  input  wire logic               b_to_a_capture_clock,
  input  wire logic [NUM_SEC-1:0] b_to_a_store_enable_n,
  input  wire logic               b_to_a_output_enable_n,
  // A-side bus pin, split into input, output and output enable.
  input  wire logic [BUS_W-1:0]   aIn,
  output logic      [BUS_W-1:0]   aOut,
  output logic      [BUS_W-1:0]   aOeN,
  // B-side bus pin, split into input, output and output enable.
  input  wire logic [BUS_W-1:0]   bIn,
  output logic      [BUS_W-1:0]   bOut,
  output logic      [BUS_W-1:0]   bOeN
);

  // Capture clock pins are sampled as ordinary synchronous inputs, so the
  // fastest usable capture rate is half of clk. This trades pin rate for
  // a single clock domain.
  logic abClkPrev; // Last sampled level of the A-to-B capture clock.
  logic baClkPrev; // Last sampled level of the B-to-A capture clock.

  // Rising edges of the capture clocks, one cycle wide unless held by a freeze.
  wire logic abEdge;
  wire logic baEdge;

  // Stored contents of the two banks.
  logic [BUS_W-1:0] abStore; // Bank feeding the B side.
  logic [BUS_W-1:0] baStore; // Bank feeding the A side.

  // Edge detection history. The reset level is a constant chosen so
  // that a pin sitting high at release does not look like an edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abClkPrev <= CAP_CLK_RESET;
      baClkPrev <= CAP_CLK_RESET;
    end else if (ce) begin
      abClkPrev <= a_to_b_capture_clock;
      baClkPrev <= b_to_a_capture_clock;
    end
  end

  // A low-to-high step of the pin is the only capture event; a pin held
  // at either level gives none, so the banks keep their data.
  assign abEdge = a_to_b_capture_clock & ~abClkPrev;
  assign baEdge = b_to_a_capture_clock & ~baClkPrev;

  // Each direction owns its own bank, built from independent sections so
  // that one section can load while its neighbour holds.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEC; gi++) begin : gSec
      // A-to-B section: A inputs go into the bank that drives B.
      rbt_section #(
        .W        (SEC_W)
      ) uAb (
        .clk      (clk),
        .ce       (ce),
        .capEdge  (abEdge),
        .storeEnN (a_to_b_store_enable_n[gi]),
        .d        (aIn[gi*SEC_W +: SEC_W]),
        .q        (abStore[gi*SEC_W +: SEC_W])
      );

      // B-to-A section: the mirror image with its own controls.
      rbt_section #(
        .W        (SEC_W)
      ) uBa (
        .clk      (clk),
        .ce       (ce),
        .capEdge  (baEdge),
        .storeEnN (b_to_a_store_enable_n[gi]),
        .d        (bIn[gi*SEC_W +: SEC_W]),
        .q        (baStore[gi*SEC_W +: SEC_W])
      );
    end
  endgenerate

  // Output enables follow the direction's enable pin directly, with no
  // register, so the pins float at once whatever the clock is doing.
  wire logic abDrive;
  wire logic baDrive;
  assign abDrive = ~a_to_b_output_enable_n;
  assign baDrive = ~b_to_a_output_enable_n;

  // Pin enables: low drives, high floats.
  assign bOeN = abDrive ? {BUS_W{PIN_DRIVE}} : {BUS_W{PIN_FLOAT}};
  assign aOeN = baDrive ? {BUS_W{PIN_DRIVE}} : {BUS_W{PIN_FLOAT}};

  // Pin data always shows the bank; the enable decides whether it is
  // seen on the wire.
  assign bOut = abStore;
  assign aOut = baStore;

  // The controller must hold every control pin at a defined level; an
  // unknown control here would corrupt the stored data without warning.

  // Record of which sections have been loaded since reset. The banks
  // carry no reset, so a section holds unknown data until its first load
  // and the hold checks below have nothing defined to compare before it.
  logic      [NUM_SEC-1:0] abLoaded; // A-to-B sections loaded once.
  logic      [NUM_SEC-1:0] baLoaded; // B-to-A sections loaded once.
  wire logic [NUM_SEC-1:0] abLoad;   // A-to-B sections loading now.
  wire logic [NUM_SEC-1:0] baLoad;   // B-to-A sections loading now.

  // The same qualification as the sections themselves use.
  assign abLoad = {NUM_SEC{ce & abEdge}} & ~a_to_b_store_enable_n;
  assign baLoad = {NUM_SEC{ce & baEdge}} & ~b_to_a_store_enable_n;

  // The record only grows. Clearing it on reset is conservative: the
  // banks keep their data, but the checks wait for a fresh load.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abLoaded <= '0;
      baLoaded <= '0;
    end else begin
      abLoaded <= abLoaded | abLoad;
      baLoaded <= baLoaded | baLoad;
    end
  end

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Disabled direction floats every B pin.
  a_ab_float: assert property (
    a_to_b_output_enable_n |-> bOeN == {BUS_W{PIN_FLOAT}})
    else $error("B pins not floating while disabled.");

  // Disabled B-to-A direction floats every A pin.
  a_ba_float: assert property (
    b_to_a_output_enable_n |-> aOeN == {BUS_W{PIN_FLOAT}})
    else $error("A pins not floating while disabled.");

  // Enabled A-to-B direction drives every B pin.
  a_ab_drive: assert property (
    !a_to_b_output_enable_n |-> bOeN == {BUS_W{PIN_DRIVE}})
    else $error("B pins not driven while enabled.");

  // Enabled B-to-A direction drives every A pin with the stored bank data.
  a_ba_drive: assert property (
    !b_to_a_output_enable_n |-> aOeN == {BUS_W{PIN_DRIVE}} && aOut == baStore)
    else $error("A pins not driven with stored data.");

  // A qualified edge loads the low section from the A inputs.
  a_ab_capture: assert property (
    ce && abEdge && !a_to_b_store_enable_n[0]
    |=> bOut[SEC_W-1:0] == $past(aIn[SEC_W-1:0]))
    else $error("A-to-B capture missed.");

  // Store enable high keeps the section unchanged across an edge.
  a_ab_hold: assert property (
    ce && a_to_b_store_enable_n[1] && abLoaded[1]
    |=> $stable(bOut[BUS_W-1:SEC_W]))
    else $error("A-to-B section changed while held.");

  // The B-to-A low section also holds while its store enable is high.
  a_ba_hold: assert property (
    ce && b_to_a_store_enable_n[0] && baLoaded[0]
    |=> $stable(aOut[SEC_W-1:0]))
    else $error("B-to-A section changed while held.");

  // A capture clock that stays put for two enabled samples loads nothing.
  // Both samples must be enabled: a rise spanning a freeze is an edge.
  a_ab_static: assert property (
    ce && $past(ce) && $stable(a_to_b_capture_clock) && (&abLoaded)
    |=> $stable(bOut))
    else $error("A-to-B data changed with static clock.");

  // The same holds for the B-to-A capture clock and the A-side bank.
  a_ba_static: assert property (
    ce && $past(ce) && $stable(b_to_a_capture_clock) && (&baLoaded)
    |=> $stable(aOut))
    else $error("B-to-A data changed with static clock.");

  // The B-to-A path captures the B inputs in the high section.
  a_ba_capture: assert property (
    ce && baEdge && !b_to_a_store_enable_n[1]
    |=> aOut[BUS_W-1:SEC_W] == $past(bIn[BUS_W-1:SEC_W]))
    else $error("B-to-A capture missed.");

  // Activity in the A-to-B direction never touches the B-to-A bank.
  a_dir_isolate: assert property (
    ce && abEdge && !baEdge && (&baLoaded) |=> $stable(aOut))
    else $error("B-to-A bank disturbed by A-to-B load.");

  // One section loads while the other holds.
  a_sec_indep: assert property (
    ce && abEdge && !a_to_b_store_enable_n[0]
    && a_to_b_store_enable_n[1] && abLoaded[1]
    |=> bOut[SEC_W-1:0] == $past(aIn[SEC_W-1:0])
        && $stable(bOut[BUS_W-1:SEC_W]))
    else $error("Sections not independent.");

  // Freeze stops both banks; checked once two frozen cycles have passed.
  a_freeze_all: assert property (
    (&abLoaded) && (&baLoaded) && !ce ##1 !ce
    |=> $stable(aOut) && $stable(bOut))
    else $error("State moved while frozen.");

  // Scenarios worth seeing.
  c_ab_load: cover property (
    ce && abEdge && a_to_b_store_enable_n == '0 ##1 !a_to_b_output_enable_n);
  c_ba_load: cover property (
    ce && baEdge && b_to_a_store_enable_n == '0 ##1 !b_to_a_output_enable_n);
  c_split: cover property (
    ce && abEdge && a_to_b_store_enable_n == 2'h1);
  c_float: cover property (
    a_to_b_output_enable_n && b_to_a_output_enable_n);
  c_freeze: cover property (
    !ce ##1 !ce ##1 ce);

endmodule

// ---- inc/rbt_pkg.sv ----
// Shared constants for the registered bidirectional bus transceiver.
package rbt_pkg;

  // Full width of each transfer direction.
  localparam int unsigned BUS_W = 18;

  // Width of one independently enabled section.
  localparam int unsigned SEC_W = 9;

  // Number of sections that make up one direction.
  localparam int unsigned NUM_SEC = 2;

  // System clock period in nanoseconds, at 200 MHz.
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Level assumed for a capture clock pin when reset releases.
  // Starting high means a pin that is already high gives no false edge.
  localparam logic CAP_CLK_RESET = 1'b1;

  // Output enable level on a pin that this block drives.
  localparam logic PIN_DRIVE = 1'b0;

  // Output enable level on a pin that this block leaves floating.
  localparam logic PIN_FLOAT = 1'b1;

endpackage

// ---- verilog/rbt_section.sv ----
`timescale 1ns/10ps

// One storage section of a direction: a group of data flip-flops that
// loads on a qualified capture edge and holds otherwise.
module rbt_section
  import rbt_pkg::*;
#(
  parameter int unsigned W = SEC_W
) (
  // Clock and global freeze.
  input  wire logic         clk,
  input  wire logic         ce,
  // Capture edge seen on the direction's capture clock pin.
  input  wire logic         capEdge,
  // Active-low store enable of this section.
  input  wire logic         storeEnN,
  // Data in and stored data out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // A load needs the freeze lifted, an edge, and the store enable low.
  wire logic load;
  assign load = ce & capEdge & ~storeEnN;

  // The storage carries no reset on purpose: it comes up unknown and is
  // defined only by the first qualified capture, as the real part does.
  always_ff @(posedge clk) begin
    if (load) begin
      q <= d;
    end
  end

endmodule

// ---- tb/rbt_bus_side.sv ----
`timescale 1ns/10ps

// Far-side bus logic on one side of the transceiver.
module rbt_bus_side
  import rbt_pkg::*;
(
  // Clock.
  input  wire logic             clk,
  // Device half of the pin.
  input  wire logic [BUS_W-1:0] devOut,
  input  wire logic [BUS_W-1:0] devOeN,
  // Far-side driver.
  input  wire logic [BUS_W-1:0] farData,
  input  wire logic             farDrive,
  // Resolved wire level.
  output logic      [BUS_W-1:0] level
);
  logic [BUS_W-1:0] last;   // Last resolved wire level.
  logic [BUS_W-1:0] farLvl; // What the far side puts on the wire.

  // An undriven wire shows the inverse of its last value, so a stale copy
  // can never pass for real data.
  assign farLvl = farDrive ? farData : ~last;
  assign level  = (~devOeN & devOut) | (devOeN & farLvl);

  // Remember the wire for the undriven case.
  always_ff @(posedge clk) begin
    last <= level;
  end
endmodule

// ---- tb/rbt_transceiver_tb.sv ----
`timescale 1ns/10ps

// Self-checking bench for the transceiver.
module rbt_transceiver_tb
  import rbt_pkg::*;
;
  logic clk = 0, rstn = 0, ce = 1;         // Clock, reset, freeze.
  logic abClk = 1, baClk = 1, abOe = 0, baOe = 1; // Controls.
  logic [1:0] abEn = 2'b11, baEn = 2'b11;  // Store enables.
  logic [BUS_W-1:0] aFar, bFar, aIn, bIn;  // Far data and wires.
  logic [BUS_W-1:0] aOut, aOeN, bOut, bOeN;
  logic [BUS_W-1:0] expA, expB;            // Expected bank contents.
  int n_mismatch = 0, checks = 0;

  always #2.5 clk = ~clk;

  rbt_transceiver uut (.clk(clk), .rstn(rstn), .ce(ce),
    .a_to_b_capture_clock(abClk), .a_to_b_store_enable_n(abEn),
    .a_to_b_output_enable_n(abOe), .b_to_a_capture_clock(baClk),
    .b_to_a_store_enable_n(baEn), .b_to_a_output_enable_n(baOe),
    .aIn(aIn), .aOut(aOut), .aOeN(aOeN),
    .bIn(bIn), .bOut(bOut), .bOeN(bOeN));
  rbt_bus_side aSide (.clk(clk), .devOut(aOut), .devOeN(aOeN),
    .farData(aFar), .farDrive(1'b1), .level(aIn));
  rbt_bus_side bSide (.clk(clk), .devOut(bOut), .devOeN(bOeN),
    .farData(bFar), .farDrive(1'b1), .level(bIn));

  // Compare one bus-wide value.
  task automatic chk(input logic [BUS_W-1:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One capture: pin low, then high with data; the edge loads it.
  task automatic cap(input bit dir, input logic [1:0] en,
                     input logic [BUS_W-1:0] d);
    @(negedge clk);
    if (dir) begin
      bFar = d; baEn = en; baClk = 0;
    end else begin
      aFar = d; abEn = en; abClk = 0;
    end
    @(negedge clk);
    if (dir) baClk = 1;
    else abClk = 1;
    @(negedge clk);
    abEn = 2'b11;
    baEn = 2'b11;
  endtask

  // Back-to-back loads, then a driven pin.
  task automatic t_capture;
    cap(0, 2'b00, 18'h2a5c3);
    cap(0, 2'b00, 18'h15a3c);
    expB = 18'h15a3c;
    chk(bOut, expB);
    chk(bOeN, '0);
    chk(bIn, expB);
  endtask

  // Store enable high, then a static pin with moving data.
  task automatic t_hold;
    cap(0, 2'b11, 18'h3ffff);
    chk(bOut, expB);
    abEn = 2'b00;
    repeat (3) begin
      @(negedge clk);
      aFar = ~aFar;
    end
    chk(bOut, expB);
    abEn = 2'b11;
  endtask

  // Each enable bit loads only its own nine bits.
  task automatic t_section;
    cap(0, 2'b10, 18'h00000);
    expB = {expB[17:9], 9'h000};
    chk(bOut, expB);
    cap(0, 2'b01, 18'h3ffff);
    expB = {9'h1ff, expB[8:0]};
    chk(bOut, expB);
  endtask

  // Reverse path, leaving the forward bank alone. The B pins are released
  // first so the far side, not the device, sets the B wire.
  task automatic t_reverse;
    abOe = 1;
    cap(1, 2'b00, 18'h0f0f0);
    expA = 18'h0f0f0;
    chk(aOut, expA);
    chk(bOut, expB);
    baOe = 0;
    @(negedge clk);
    chk(aOeN, '0);
    chk(aIn, expA);
  endtask

  // Freeze: capture pins toggle with loads enabled, yet nothing moves,
  // and the rise spent inside the freeze gives no edge on resume.
  task automatic t_freeze;
    ce = 0;
    abEn = 2'b00;
    baEn = 2'b00;
    bFar = 18'h33333;
    abClk = 0;
    baClk = 0;
    repeat (2) @(negedge clk);
    abClk = 1;
    baClk = 1;
    repeat (2) @(negedge clk);
    chk(bOut, expB);
    chk(aOut, expA);
    ce = 1;
    repeat (2) @(negedge clk);
    chk(bOut, expB);
    chk(aOut, expA);
    abEn = 2'b11;
    baEn = 2'b11;
  endtask

  // Disabled directions float every pin.
  task automatic t_float;
    abOe = 1;
    baOe = 1;
    #1;
    chk(bOeN, '1);
    chk(aOeN, '1);
  endtask

  // Report counts and end the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence; every control is driven to a defined level.
  initial begin
    aFar = 18'h00000;
    bFar = 18'h00000;
    repeat (5) @(negedge clk);
    rstn = 1;
    t_capture();
    t_hold();
    t_section();
    t_reverse();
    t_freeze();
    t_float();
    give_verdict();
  end

  // A hang counts as a mismatch.
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
